// File: logic/jtg_map.svh
`ifndef JTG_MAP_SVH
`define JTG_MAP_SVH

// register offsets on the system port
`define JTG_OFF_INSTR 4'h0
`define JTG_OFF_STAT 4'h4
`define JTG_OFF_CTRL 4'h8

// status and control bit positions
`define JTG_STAT_DBGRST 0
`define JTG_STAT_IRQ 1
`define JTG_STAT_EXT 2
`define JTG_STAT_HIZ 3
`define JTG_CTRL_IRQEN 0
`define JTG_CTRL_IRQCLR 1

// instruction field values
`define JTG_IR_RESET 8'hef
`define JTG_IR_CAPTURE 8'h01
`define JTG_IR_LOW_BYTE 8'hfd
`define JTG_OP_EXTEST 4'h0
`define JTG_OP_CLAMP 4'h2
`define JTG_OP_HIGHZ 4'h3
`define JTG_OP_SAMPLE 4'h4
`define JTG_OP_DBGNEG 4'h6
`define JTG_OP_DBGAST 4'h7
`define JTG_OP_IRQ 3'h5
`define JTG_OP_IDCODE 4'he
`define JTG_OP_BYPASS 4'hf

// pad scan chain layout
`define JTG_BSR_LEN 385
`define JTG_BSR_IN_HI 384
`define JTG_BSR_IN_LO 351
`define JTG_BSR_OUT_HI 350
`define JTG_BSR_OUT_LO 317
`define JTG_BSR_CTL_HI 316
`define JTG_BSR_CTL_LO 283
`define JTG_NPIN 34

`endif

// File: logic/jtg_pkg.sv
`default_nettype none
`include "jtg_map.svh"
package jtg_pkg;

  typedef enum logic [3:0] {
    TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PA_DR,
    TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR,
    TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
  } jtg_tap_state_t;

  typedef enum logic [3:0] {
    INS_EXTEST, INS_CLAMP, INS_HIGHZ, INS_SAMPLE, INS_DBGNEG, INS_DBGAST,
    INS_IRQ, INS_IDCODE, INS_BYPASS, INS_RSVD
  } jtg_instr_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } jtg_bus_req_t;

  typedef struct packed {
    logic [`JTG_NPIN-1:0] out;
    logic [`JTG_NPIN-1:0] oe;
  } jtg_pin_t;

  // settings handed from the test clock side to the system side
  typedef struct packed {
    logic [7:0] code;
    logic dbg_rst;
    logic [`JTG_NPIN-1:0] bnd_ctl;
    logic [`JTG_NPIN-1:0] bnd_out;
  } jtg_cfg_t;

  // lower nibble of the field is a don't care
  function automatic jtg_instr_t jtg_decode(input logic [7:0] code);
    jtg_instr_t ins;
    ins = INS_RSVD;
    if (code[7:5] == `JTG_OP_IRQ) begin
      ins = INS_IRQ;
    end else if (code[7:4] == `JTG_OP_EXTEST) begin
      ins = INS_EXTEST;
    end else if (code[7:4] == `JTG_OP_CLAMP) begin
      ins = INS_CLAMP;
    end else if (code[7:4] == `JTG_OP_HIGHZ) begin
      ins = INS_HIGHZ;
    end else if (code[7:4] == `JTG_OP_SAMPLE) begin
      ins = INS_SAMPLE;
    end else if (code[7:4] == `JTG_OP_DBGNEG) begin
      ins = INS_DBGNEG;
    end else if (code[7:4] == `JTG_OP_DBGAST) begin
      ins = INS_DBGAST;
    end else if (code[7:4] == `JTG_OP_IDCODE) begin
      ins = INS_IDCODE;
    end else if (code[7:4] == `JTG_OP_BYPASS) begin
      ins = INS_BYPASS;
    end
    return ins;
  endfunction

endpackage
`default_nettype wire

// File: logic/jtg_tap_fsm.sv
`default_nettype none
module jtg_tap_fsm (
  // test link
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  // controller state
  output jtg_pkg::jtg_tap_state_t state
);
  import jtg_pkg::*;

  typedef struct packed {
    jtg_tap_state_t st;
  } jtg_fsm_reg_t;

  jtg_fsm_reg_t s_r;
  jtg_fsm_reg_t s_nxt;

  // standard sixteen-state walk steered by tms
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      TAP_TLR: s_nxt.st = tms ? TAP_TLR : TAP_RTI;
      TAP_RTI: s_nxt.st = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_DR: s_nxt.st = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: s_nxt.st = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR: s_nxt.st = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: s_nxt.st = tms ? TAP_UPD_DR : TAP_PA_DR;
      TAP_PA_DR: s_nxt.st = tms ? TAP_EX2_DR : TAP_PA_DR;
      TAP_EX2_DR: s_nxt.st = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: s_nxt.st = tms ? TAP_SEL_DR : TAP_RTI;
      TAP_SEL_IR: s_nxt.st = tms ? TAP_TLR : TAP_CAP_IR;
      TAP_CAP_IR: s_nxt.st = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR: s_nxt.st = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: s_nxt.st = tms ? TAP_UPD_IR : TAP_PA_IR;
      TAP_PA_IR: s_nxt.st = tms ? TAP_EX2_IR : TAP_PA_IR;
      TAP_EX2_IR: s_nxt.st = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: s_nxt.st = tms ? TAP_SEL_DR : TAP_RTI;
      default: s_nxt.st = TAP_TLR;
    endcase
  end

  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      s_r <= '{st: TAP_TLR};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign state = s_r.st;

endmodule
`default_nettype wire

// File: logic/jtg_xfer.sv
`default_nettype none
module jtg_xfer #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // sending domain
  input wire logic src_clk,
  input wire logic src_rst_n,
  input wire logic src_send,
  input wire logic [W-1:0] src_data,
  // receiving domain
  input wire logic dst_clk,
  input wire logic dst_rst_n,
  output logic [W-1:0] dst_data,
  output logic dst_pulse
);

  // held word plus a toggle; the word must stay put until the toggle is seen
  typedef struct packed {
    logic [W-1:0] hold;
    logic tog;
  } jtg_src_reg_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic [W-1:0] data;
    logic pulse;
  } jtg_dst_reg_t;

  jtg_src_reg_t a_r;
  jtg_src_reg_t a_nxt;
  jtg_dst_reg_t b_r;
  jtg_dst_reg_t b_nxt;

  always_comb begin
    a_nxt = a_r;
    if (src_send) begin
      a_nxt.hold = src_data;
      a_nxt.tog = ~a_r.tog;
    end
  end

  always_ff @(posedge src_clk or negedge src_rst_n) begin
    if (!src_rst_n) begin
      a_r <= '{hold: INIT, tog: 1'b0};
    end else begin
      a_r <= a_nxt;
    end
  end

  // s1 feeds only s2; the edge is taken between s2 and s3
  always_comb begin
    b_nxt = b_r;
    b_nxt.s1 = a_r.tog;
    b_nxt.s2 = b_r.s1;
    b_nxt.s3 = b_r.s2;
    b_nxt.pulse = b_r.s2 ^ b_r.s3;
    if (b_r.s2 ^ b_r.s3) begin
      b_nxt.data = a_r.hold;
    end
  end

  always_ff @(posedge dst_clk or negedge dst_rst_n) begin
    if (!dst_rst_n) begin
      b_r <= '{s1: 1'b0, s2: 1'b0, s3: 1'b0, data: INIT, pulse: 1'b0};
    end else begin
      b_r <= b_nxt;
    end
  end

  assign dst_data = b_r.data;
  assign dst_pulse = b_r.pulse;

endmodule
`default_nettype wire

// File: logic/jtg_tap_scan.sv
// Contract
// - a one-bit bypass cell, hidden from software, is the only tdi-to-tdo path under bypass.
// - the bypass cell is cleared each time the controller passes through Capture-DR.
// - the instruction register is 16 bits and software may only read it.
// - test reset or the Test-Logic-Reset state loads the identification instruction.
// - a new instruction can be shifted in at any time, whatever the processor does.
// - the instruction field, bits 15 to 8, is filled from tdi one bit per shift clock.
// - reserved instruction bits 7 to 2 and 0 read as one, bit 1 reads as zero.
// - the top nibble selects extest, clamp, highz, sample, idcode or bypass; the rest is ignored.
// - nibble 0110 releases and 0111 asserts the debug reset, and 101x raises a debug request.
// - a 385-cell pad scan chain with undefined start content, hidden from software.
// - extest, sample/preload, clamp and highz select the pad chain with standard behaviour.
// - cell 384 is next to tdi, 384 to 351 capture pins, 350 down drive the same pins in order.
// - test reset is active low, asynchronous, and held low through power-on reset.
//
// The address map and the plain strobed port were decided locally.
`default_nettype none
`include "jtg_map.svh"
module jtg_tap_scan #(
  parameter logic [31:0] IDCODE_VAL = 32'h0000_0001 // arbitrary value, bit 0 must stay one
) (
  // system side
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire jtg_pkg::jtg_bus_req_t BUS_REQ,
  output logic [15:0] RD_DATA,
  // test link
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TMS,
  input wire logic TDI,
  output logic TDO,
  output logic TDO_OE,
  // pads
  input wire logic [`JTG_NPIN-1:0] PAD_IN,
  input wire jtg_pkg::jtg_pin_t CORE_PIN,
  output jtg_pkg::jtg_pin_t PAD_PIN,
  // debug port controls
  output logic DBG_RESET,
  output logic DBG_IRQ
);
  import jtg_pkg::*;

  localparam jtg_cfg_t CFG_INIT = '{code: `JTG_IR_RESET, dbg_rst: 1'b0,
                                    bnd_ctl: '0, bnd_out: '0};

  // test clock side state
  typedef struct packed {
    logic [7:0] ir_shift;
    logic [7:0] ir;
    logic byp;
    logic [31:0] idr;
    logic [`JTG_BSR_LEN-1:0] bsr;
    logic [`JTG_BSR_LEN-1:0] bsr_upd;
    logic [`JTG_NPIN-1:0] pad_s1;
    logic [`JTG_NPIN-1:0] pad_s2;
    logic dbg_rst;
    logic was_tlr;
  } jtg_tck_reg_t;
  // identification instruction in the field, capture pattern in the shift stage
  localparam jtg_tck_reg_t T_INIT = '{ir_shift: `JTG_IR_CAPTURE, ir: `JTG_IR_RESET,
                                      was_tlr: 1'b1, default: '0};

  // system clock side state
  typedef struct packed {
    jtg_pin_t pad;
    logic irq_pend;
    logic irq_en;
    logic irq_out;
    logic dbg_out;
    logic [15:0] rd_data;
  } jtg_clk_reg_t;

  jtg_tck_reg_t t_r;
  jtg_tck_reg_t t_nxt;
  jtg_clk_reg_t c_r;
  jtg_clk_reg_t c_nxt;
  jtg_tap_state_t tap;
  jtg_instr_t ins_t;
  jtg_instr_t ins_new;
  jtg_instr_t ins_c;
  logic sel_bsr;
  logic cfg_send;
  logic irq_send;
  jtg_cfg_t cfg_src;
  jtg_cfg_t cfg;
  logic irq_evt;
  logic tdo_r;
  logic tdo_oe_r;
  logic ext_c;
  logic hiz_c;
  logic [1:0] trst_sync_r;
  logic cfg_rst_n;

  // controller walk, reset by TRST_N alone
  jtg_tap_fsm u_fsm (
    .tck(TCK),
    .trst_n(TRST_N),
    .tms(TMS),
    .state(tap)
  );

  // test clock side: capture, shift and update of all chains
  always_comb begin
    t_nxt = t_r;
    cfg_send = 1'b0;
    irq_send = 1'b0;
    ins_t = jtg_decode(t_r.ir);
    ins_new = jtg_decode(t_r.ir_shift);
    sel_bsr = (ins_t == INS_EXTEST) || (ins_t == INS_SAMPLE) ||
              (ins_t == INS_CLAMP) || (ins_t == INS_HIGHZ);
    // pins cross into the test clock domain through two flops
    t_nxt.pad_s1 = PAD_IN;
    t_nxt.pad_s2 = t_r.pad_s1;
    t_nxt.was_tlr = (tap == TAP_TLR);
    case (tap)
      TAP_TLR: begin
        t_nxt.ir = `JTG_IR_RESET;
        cfg_send = !t_r.was_tlr; // one hand-over on entry, not every cycle
      end
      TAP_CAP_IR: begin
        t_nxt.ir_shift = `JTG_IR_CAPTURE;
      end
      TAP_SH_IR: begin
        t_nxt.ir_shift = {TDI, t_r.ir_shift[7:1]};
      end
      TAP_UPD_IR: begin
        t_nxt.ir = t_r.ir_shift;
        cfg_send = 1'b1;
        if (ins_new == INS_DBGNEG) begin
          t_nxt.dbg_rst = 1'b0;
        end else if (ins_new == INS_DBGAST) begin
          t_nxt.dbg_rst = 1'b1;
        end
        irq_send = (ins_new == INS_IRQ);
      end
      TAP_CAP_DR: begin
        t_nxt.byp = 1'b0;
        t_nxt.idr = IDCODE_VAL | 32'h0000_0001;
        if (sel_bsr) begin
          // non-input cells capture what they currently hold
          t_nxt.bsr = t_r.bsr_upd;
          t_nxt.bsr[`JTG_BSR_IN_HI:`JTG_BSR_IN_LO] = t_r.pad_s2;
        end
      end
      TAP_SH_DR: begin
        if (sel_bsr) begin
          t_nxt.bsr = {TDI, t_r.bsr[`JTG_BSR_LEN-1:1]};
        end else if (ins_t == INS_IDCODE) begin
          t_nxt.idr = {TDI, t_r.idr[31:1]};
        end else begin
          t_nxt.byp = TDI;
        end
      end
      TAP_UPD_DR: begin
        if (sel_bsr) begin
          t_nxt.bsr_upd = t_r.bsr;
          cfg_send = 1'b1;
        end
      end
      default: begin
        cfg_send = 1'b0;
      end
    endcase
    // word handed to the system side, taken from the values being loaded
    cfg_src.code = t_nxt.ir;
    cfg_src.dbg_rst = t_nxt.dbg_rst;
    cfg_src.bnd_out = t_nxt.bsr_upd[`JTG_BSR_OUT_HI:`JTG_BSR_OUT_LO];
    cfg_src.bnd_ctl = t_nxt.bsr_upd[`JTG_BSR_CTL_HI:`JTG_BSR_CTL_LO];
  end

  // chains are cleared as well: any start content is legal for them, and one
  // process keeps the whole state struct under a single driver
  always_ff @(posedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      t_r <= T_INIT;
    end else begin
      t_r <= t_nxt;
    end
  end

  // tdo moves on the falling edge so the tester samples it mid-bit
  always_ff @(negedge TCK or negedge TRST_N) begin
    if (!TRST_N) begin
      tdo_r <= 1'b0;
      tdo_oe_r <= 1'b0;
    end else if (tap == TAP_SH_IR) begin
      tdo_r <= t_r.ir_shift[0];
      tdo_oe_r <= 1'b1;
    end else if (tap == TAP_SH_DR) begin
      tdo_oe_r <= 1'b1;
      if (sel_bsr) begin
        tdo_r <= t_r.bsr[0];
      end else if (ins_t == INS_IDCODE) begin
        tdo_r <= t_r.idr[0];
      end else begin
        tdo_r <= t_r.byp;
      end
    end else begin
      tdo_oe_r <= 1'b0;
    end
  end

  assign TDO = tdo_r;
  assign TDO_OE = tdo_oe_r;

  // test reset reaches the system side too: it asserts at once and releases
  // two clocks later, so the handed-over settings fall back to the reset word
  // however many toggles were in flight
  always_ff @(posedge CLOCK or negedge TRST_N) begin
    if (!TRST_N) begin
      trst_sync_r <= 2'b00;
    end else begin
      trst_sync_r <= {trst_sync_r[0], 1'b1};
    end
  end
  assign cfg_rst_n = RST_N && trst_sync_r[1];

  // settings word crosses on a toggle; updates are at least three tck apart
  jtg_xfer #(.W($bits(jtg_cfg_t)), .INIT(CFG_INIT)) u_cfg_xfer (
    .src_clk(TCK),
    .src_rst_n(TRST_N),
    .src_send(cfg_send),
    .src_data(cfg_src),
    .dst_clk(CLOCK),
    .dst_rst_n(cfg_rst_n),
    .dst_data(cfg),
    .dst_pulse()
  );

  // debug request crosses as an event
  jtg_xfer #(.W(1), .INIT(1'b0)) u_irq_xfer (
    .src_clk(TCK),
    .src_rst_n(TRST_N),
    .src_send(irq_send),
    .src_data(1'b1),
    .dst_clk(CLOCK),
    .dst_rst_n(cfg_rst_n),
    .dst_data(),
    .dst_pulse(irq_evt)
  );

  // system side: pad drive, request flag and register reads
  always_comb begin
    c_nxt = c_r;
    ins_c = jtg_decode(cfg.code);
    ext_c = (ins_c == INS_EXTEST) || (ins_c == INS_CLAMP);
    hiz_c = (ins_c == INS_HIGHZ);
    // sample/preload leaves the core in charge of the pins
    if (ext_c) begin
      c_nxt.pad.out = cfg.bnd_out;
      c_nxt.pad.oe = cfg.bnd_ctl;
    end else begin
      c_nxt.pad.out = CORE_PIN.out;
      c_nxt.pad.oe = CORE_PIN.oe;
    end
    if (hiz_c) begin
      c_nxt.pad.oe = '0;
    end
    c_nxt.dbg_out = cfg.dbg_rst;
    if (BUS_REQ.wr && (BUS_REQ.addr == `JTG_OFF_CTRL)) begin
      c_nxt.irq_en = BUS_REQ.wdata[`JTG_CTRL_IRQEN];
      if (BUS_REQ.wdata[`JTG_CTRL_IRQCLR]) begin
        c_nxt.irq_pend = 1'b0;
      end
    end
    // a new request in the clearing cycle is kept
    if (irq_evt) begin
      c_nxt.irq_pend = 1'b1;
    end
    c_nxt.irq_out = c_nxt.irq_pend && c_nxt.irq_en;
    // read data stands for one cycle only
    c_nxt.rd_data = 16'h0000;
    if (BUS_REQ.rd) begin
      if (BUS_REQ.addr == `JTG_OFF_INSTR) begin
        c_nxt.rd_data = {cfg.code, `JTG_IR_LOW_BYTE};
      end else if (BUS_REQ.addr == `JTG_OFF_STAT) begin
        c_nxt.rd_data[`JTG_STAT_DBGRST] = c_r.dbg_out;
        c_nxt.rd_data[`JTG_STAT_IRQ] = c_r.irq_pend;
        c_nxt.rd_data[`JTG_STAT_EXT] = ext_c;
        c_nxt.rd_data[`JTG_STAT_HIZ] = hiz_c;
      end else if (BUS_REQ.addr == `JTG_OFF_CTRL) begin
        c_nxt.rd_data[`JTG_CTRL_IRQEN] = c_r.irq_en;
      end
    end
  end

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      c_r <= '0;
    end else begin
      c_r <= c_nxt;
    end
  end

  assign RD_DATA = c_r.rd_data;
  assign PAD_PIN = c_r.pad;
  assign DBG_RESET = c_r.dbg_out;
  assign DBG_IRQ = c_r.irq_out;

endmodule
`default_nettype wire

// File: tb/jtg_tester.sv
`default_nettype none
module jtg_tester (
  // test link
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ns;
  // clock stands low between frames, tms and tdi rest at their pull-up level
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // one 32 ns test clock; tdo is taken at the rise, it moved at the last fall
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #8 tck = 1'b1;
    o = tdo;
    #16 tck = 1'b0;
    #8;
  endtask
  // run-test/idle, select, capture, shift lsb first, update, back to idle
  task automatic scan(input bit ir, input logic din[$], output logic dout[$]);
    logic o;
    dout = {};
    step(1'b0, 1'b1, o);
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    foreach (din[k]) begin
      step(k == din.size() - 1, din[k], o);
      dout.push_back(o);
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    tms = 1'b1;
    tdi = 1'b1;
  endtask
endmodule
`default_nettype wire

// File: tb/jtg_tap_scan_props.sv
`default_nettype none
module jtg_tap_scan_props (
  // system side
  input wire logic CLOCK,
  input wire logic RST_N,
  input wire jtg_pkg::jtg_bus_req_t BUS_REQ,
  input wire logic [15:0] RD_DATA,
  // test link
  input wire logic TCK,
  input wire logic TRST_N,
  input wire logic TDO_OE,
  // pads and debug
  input wire jtg_pkg::jtg_pin_t CORE_PIN,
  input wire jtg_pkg::jtg_pin_t PAD_PIN,
  input wire logic DBG_RESET,
  input wire logic DBG_IRQ
);
  import jtg_pkg::*;
  // status reads line up with the pad outputs and trail the debug output by a cycle; the extra ##1 waits one cycle more
  rd_low_byte_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == 4'h0 |=> RD_DATA[7:0] == 8'hfd)
    else $error("instruction low byte wrong");
  rd_idle_zero_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !BUS_REQ.rd |=> RD_DATA == 16'h0000)
    else $error("read data not idle");
  rd_unmapped_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    BUS_REQ.rd && !(BUS_REQ.addr inside {4'h0, 4'h4, 4'h8}) |=> RD_DATA == 16'h0000)
    else $error("unmapped read not zero");
  irq_off_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    BUS_REQ.wr && BUS_REQ.addr == 4'h8 && !BUS_REQ.wdata[0] |-> ##[1:3] !DBG_IRQ)
    else $error("request stays up when disabled");
  hiz_pins_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == 4'h4 ##1 RD_DATA[3] |=> ##1 PAD_PIN.oe == '0)
    else $error("pins driven in high impedance mode");
  dbgrst_level_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == 4'h4 ##1 RD_DATA[0] |=> ##1 DBG_RESET)
    else $error("debug reset level missing");
  pad_follow_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    BUS_REQ.rd && BUS_REQ.addr == 4'h4 ##1 RD_DATA[3:2] == 2'b00
    |=> ##1 PAD_PIN == $past(CORE_PIN))
    else $error("pins not following core");
  oe_reset_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
    !TRST_N |-> !TDO_OE)
    else $error("serial output enabled after test reset");
  // main scenarios reached
  cover property (@(posedge CLOCK) disable iff (!RST_N) $rose(DBG_IRQ));
  cover property (@(posedge CLOCK) disable iff (!RST_N) $rose(DBG_RESET));
  cover property (@(posedge TCK) disable iff (!TRST_N) $rose(TDO_OE));
endmodule
bind jtg_tap_scan jtg_tap_scan_props props (.CLOCK(CLOCK), .RST_N(RST_N), .BUS_REQ(BUS_REQ),
  .RD_DATA(RD_DATA), .TCK(TCK), .TRST_N(TRST_N), .TDO_OE(TDO_OE), .CORE_PIN(CORE_PIN),
  .PAD_PIN(PAD_PIN), .DBG_RESET(DBG_RESET), .DBG_IRQ(DBG_IRQ));
`default_nettype wire

// File: tb/jtag_tap_scan_registers_bench.sv
`default_nettype none
module jtag_tap_scan_registers_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import jtg_pkg::*;
  localparam logic [31:0] IDC = 32'h5a3c_0e70; // arbitrary value, bit 0 left low on purpose
  localparam logic [31:0] IDE = IDC | 32'h0000_0001;
  logic CLOCK = 1'b0;
  logic RST_N = 1'b0;
  logic TRST_N = 1'b0;
  jtg_bus_req_t req = '0;
  jtg_pin_t core = '0;
  jtg_pin_t pad;
  logic [33:0] pin_in = '0;
  logic [15:0] rdata, d;
  wire logic tck, tms, tdi, tdo, tdo_oe, dbg_rst, dbg_irq;
  integer seed = 92910;
  int n_mismatch = 0;
  int checks = 0;
  int n;
  logic [3:0] st = '0;
  logic [384:0] lat;
  bit lat_ok = 1'b0;
  logic q_in[$];
  logic q_out[$];
  logic [7:0] code;
  // every command once, debug request twice (both 101x codes); debug assert twice so the final test reset has work to do
  logic [3:0] ops [11] = '{4'he, 4'h4, 4'h0, 4'h2, 4'h3, 4'h7, 4'ha, 4'h6, 4'hb, 4'h7, 4'hf};

  always #25 CLOCK = ~CLOCK;

  jtg_tap_scan #(.IDCODE_VAL(IDC)) uut (.CLOCK(CLOCK), .RST_N(RST_N), .BUS_REQ(req),
    .RD_DATA(rdata), .TCK(tck), .TRST_N(TRST_N), .TMS(tms), .TDI(tdi), .TDO(tdo),
    .TDO_OE(tdo_oe), .PAD_IN(pin_in), .CORE_PIN(core), .PAD_PIN(pad),
    .DBG_RESET(dbg_rst), .DBG_IRQ(dbg_irq));
  jtg_tester tst (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));

  // comparisons
  task automatic note(input bit ok, input string what);
    checks++;
    if (!ok) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, what);
    end
  endtask
  task automatic chk_word(input logic [15:0] g, input logic [15:0] e);
    note(g === e, $sformatf("word %h exp %h", g, e));
  endtask
  task automatic chk_bit(input logic g, input logic e);
    note(g === e, "bit");
  endtask
  task automatic chk_pin(input logic [33:0] g, input logic [33:0] e);
    note(g === e, $sformatf("pins %h exp %h", g, e));
  endtask
  // bus cycles, each strobe one cycle; read data taken mid-cycle after the strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge CLOCK);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge CLOCK);
    req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge CLOCK);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge CLOCK);
    req <= '0;
    @(negedge CLOCK);
    v = rdata;
  endtask
  task automatic print_verdict;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (10) @(posedge CLOCK);
    RST_N <= 1'b1;
    TRST_N <= 1'b1;
    rd(4'h0, d);
    chk_word(d, 16'hef_fd);
    wr(4'h0, 16'h0000);
    rd(4'h0, d);
    chk_word(d, 16'hef_fd);
    rd(4'hc, d);
    chk_word(d, 16'h0000);
    wr(4'h8, 16'h0001);
    foreach (ops[i]) begin
      code = {ops[i], 4'($random(seed))};
      pin_in <= 34'({$random(seed), $random(seed)});
      core <= 68'({$random(seed), $random(seed), $random(seed)});
      q_in = {};
      for (int k = 0; k < 8; k++) q_in.push_back(code[k]);
      tst.scan(1'b1, q_in, q_out);
      for (int k = 0; k < 8; k++) chk_bit(q_out[k], k == 0);
      chk_bit(tdo_oe, 1'b0);
      if (ops[i] == 4'h7) st[0] = 1'b1;
      if (ops[i] == 4'h6) st[0] = 1'b0;
      if (ops[i][3:1] == 3'b101) st[1] = 1'b1;
      st[2] = ops[i] == 4'h0 || ops[i] == 4'h2;
      st[3] = ops[i] == 4'h3;
      repeat (10) @(posedge CLOCK);
      rd(4'h0, d);
      chk_word(d, {code, 8'hfd});
      rd(4'h4, d);
      chk_word(d, {12'h000, st});
      chk_bit(dbg_rst, st[0]);
      chk_bit(dbg_irq, st[1]);
      // clearing also disables, so the request must drop and stay down
      if (st[1]) begin
        wr(4'h8, 16'h0002);
        st[1] = 1'b0;
        repeat (3) @(posedge CLOCK);
        rd(4'h4, d);
        chk_word(d, {12'h000, st});
        chk_bit(dbg_irq, 1'b0);
        wr(4'h8, 16'h0001);
      end
      n = ops[i] inside {4'h0, 4'h2, 4'h3, 4'h4} ? 385 : ops[i] == 4'he ? 32 : 8;
      q_in = {};
      repeat (n) q_in.push_back(1'($random(seed)));
      tst.scan(1'b0, q_in, q_out);
      for (int k = 0; k < n; k++) begin
        if (n == 32) chk_bit(q_out[k], IDE[k]);
        else if (n == 8) chk_bit(q_out[k], k == 0 ? 1'b0 : q_in[k - 1]);
        else if (k > 350) chk_bit(q_out[k], pin_in[k - 351]);
        else if (lat_ok) chk_bit(q_out[k], lat[k]);
      end
      if (n == 385) begin
        foreach (q_in[k]) lat[k] = q_in[k];
        lat_ok = 1'b1;
      end
      repeat (10) @(posedge CLOCK);
      if (st[3]) chk_pin(pad.oe, '0);
      else if (st[2]) begin
        chk_pin(pad.out, lat[350:317]);
        chk_pin(pad.oe, lat[316:283]);
      end else begin
        chk_pin(pad.out, core.out);
        chk_pin(pad.oe, core.oe);
      end
    end
    TRST_N <= 1'b0;
    repeat (3) @(posedge CLOCK);
    TRST_N <= 1'b1;
    repeat (10) @(posedge CLOCK);
    rd(4'h0, d);
    chk_word(d, 16'hef_fd);
    chk_bit(dbg_rst, 1'b0);
    print_verdict();
  end

  // a hung scan or bus cycle ends the run instead of stalling it
  initial begin
    #1000000;
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
